//--- hw/crcu_byte_step.sv
// Purpose: advance a crc state by one data byte, msb first
// Assumes: coefficients sit in the low bits for narrow widths
// Notes: purely combinational, one byte per clock in the caller
`timescale 1ns/1ps
module crcu_byte_step (
    input wire logic [31:0] crc_in,
    input wire logic [7:0] byte_in,
    input wire logic [31:0] coeffs,
    input wire logic [1:0] width_sel,
    output logic [31:0] crc_out
);
    import crcu_pkg::*;

    logic [31:0] mask;
    logic [4:0] top;
    logic [31:0] acc;
    logic fb;

    // ****************************************************************
    // width decode
    // ****************************************************************
    always_comb begin
        case (width_sel)
            WIDTH_16: begin
                mask = MASK_16;
                top = TOP_16;
            end
            WIDTH_8: begin
                mask = MASK_8;
                top = TOP_8;
            end
            WIDTH_7: begin
                mask = MASK_7;
                top = TOP_7;
            end
            default: begin
                mask = MASK_32;
                top = TOP_32;
            end
        endcase
    end

    // ****************************************************************
    // bit-serial division unrolled over eight bits
    // ****************************************************************
    // masking keeps narrow results in the low bits [R3] [R13]
    always_comb begin
        acc = crc_in;
        fb = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            fb = acc[top] ^ byte_in[i]; // msb of the byte first [R20]
            acc = (acc << 1) & mask;
            if (fb) begin
                acc = acc ^ (coeffs & mask); // [R20]
            end
        end
        crc_out = acc;
    end
endmodule

//--- hw/crcu_pkg.sv
// Purpose: shared constants and types of the crc calculation unit
// Assumes: byte addresses on the bus, 32-bit data
// Notes: register offsets, field positions and reset values live here
package crcu_pkg;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam int ADDR_W = 5;
    localparam logic [ADDR_W-1:0] OFF_DATA = 5'h00;
    localparam logic [ADDR_W-1:0] OFF_SCRATCH = 5'h04;
    localparam logic [ADDR_W-1:0] OFF_CTRL = 5'h08;
    localparam logic [ADDR_W-1:0] OFF_SEED = 5'h10;
    localparam logic [ADDR_W-1:0] OFF_COEFFS = 5'h14;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [31:0] DATA_RST = 32'hFFFFFFFF;
    localparam logic [31:0] SEED_RST = 32'hFFFFFFFF;
    localparam logic [31:0] COEFFS_RST = 32'h04C11DB7;
    localparam logic [7:0] SCRATCH_RST = 8'h00;

    // ****************************************************************
    // control field positions
    // ****************************************************************
    localparam int CTRL_RST_BIT = 0;
    localparam int CTRL_WIDTH_LO = 3;
    localparam int CTRL_IN_LO = 5;
    localparam int CTRL_OUT_BIT = 7;

    // ****************************************************************
    // encodings and counts
    // ****************************************************************
    localparam logic [1:0] WIDTH_32 = 2'h0;
    localparam logic [1:0] WIDTH_16 = 2'h1;
    localparam logic [1:0] WIDTH_8 = 2'h2;
    localparam logic [1:0] WIDTH_7 = 2'h3;
    localparam logic [31:0] MASK_32 = 32'hFFFFFFFF;
    localparam logic [31:0] MASK_16 = 32'h0000FFFF;
    localparam logic [31:0] MASK_8 = 32'h000000FF;
    localparam logic [31:0] MASK_7 = 32'h0000007F;
    localparam logic [4:0] TOP_32 = 5'h1F;
    localparam logic [4:0] TOP_16 = 5'h0F;
    localparam logic [4:0] TOP_8 = 5'h07;
    localparam logic [4:0] TOP_7 = 5'h06;
    localparam logic [1:0] FLIP_NONE = 2'h0;
    localparam logic [1:0] FLIP_BYTE = 2'h1;
    localparam logic [1:0] FLIP_HALF = 2'h2;
    localparam logic [1:0] FLIP_WORD = 2'h3;
    localparam logic [2:0] SIZE_BYTE = 3'h0;
    localparam logic [2:0] SIZE_HALF = 3'h1;
    localparam logic [2:0] SIZE_WORD = 3'h2;
    // cycles of computation equal bytes in the written unit
    localparam logic [2:0] CYC_WORD = 3'h4;
    localparam logic [2:0] CYC_HALF = 3'h2;
    localparam logic [2:0] CYC_BYTE = 3'h1;

    typedef enum logic {
        CRCU_IDLE = 1'b0,
        CRCU_RUN = 1'b1
    } crcu_eng_t;

endpackage

//--- hw/crcu_top.sv
// Purpose: crc calculation unit with its register file on ahb-lite
// Assumes: single clock clk_sys, synchronous active-high rst
// Notes: data port computes one byte per clock behind a one-entry buffer
// Overview of operation
// R1: a data port write feeds the value into the crc with the held result
// R2: a data port read returns the latest completed crc result
// R3: narrow data and crc values use the low bits of the data port
// R4: scratch register holds eight read/write bits, no effect on the crc
// R5: scratch byte survives the control reset bit
// R6: control bit 7 set presents the read result fully bit-reversed
// R7: control bits 6:5 pick input reversal: none, byte, half, word
// R8: control bits 4:3 pick crc width: 32, 16, 8 or 7 bits
// R9: writing control bit 0 reloads the data port from the seed
// R10: control bit 0 clears itself; writing zero does nothing
// R11: seed register at 0x10 holds 32 bits, resets to all ones
// R12: coefficient register at 0x14 resets to 0x04C11DB7
// R13: software puts narrow coefficients in the low bits
// R14: after reset data reads all ones, control and scratch read zero
// R15: software writes zero to reserved bits
// R16: computation takes four, two or one clocks for word, half, byte
// R17: any seed write also loads the data port with the seed
// R18: a second data write is taken at once while computing
// R19: data port takes word, half and byte; others only full words
// R20: each unit is processed msb first, one bit shift per data bit
`timescale 1ns/1ps
module crcu_top (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata
);
    import crcu_pkg::*;

    typedef struct packed {
        crcu_eng_t eng;
        logic [31:0] crc;
        logic [31:0] work;
        logic [2:0] cnt;
        logic buf_valid;
        logic [31:0] buf_data;
        logic [2:0] buf_cnt;
        logic [7:0] scratch;
        logic output_bit_flip;
        logic [1:0] input_bit_flip;
        logic [1:0] generator_width;
        logic soft_rst;
        logic [31:0] seed;
        logic [31:0] coeffs;
        logic a_valid;
        logic a_write;
        logic [ADDR_W-1:0] a_addr;
        logic [2:0] a_size;
        logic [31:0] rdata;
    } crcu_state_t;

    crcu_state_t r;
    crcu_state_t nxt;
    logic [31:0] step_crc;
    logic blocked;
    logic dphase;
    logic wr_fire;
    logic wr_word;
    logic accept;
    logic abort;
    logic [1:0] eff_flip;
    logic [31:0] din_flip;
    logic [31:0] din_aligned;
    logic [2:0] din_cnt;
    logic [ADDR_W-1:0] rd_addr;

    // ****************************************************************
    // bit reversal helpers
    // ****************************************************************
    function automatic logic [31:0] flip_lanes(input logic [31:0] d,
                                               input logic [1:0] mode);
        logic [31:0] f;
        f = d;
        for (int i = 0; i < 32; i++) begin
            case (mode)
                FLIP_BYTE: f[i] = d[(i / 8) * 8 + 7 - (i % 8)];
                FLIP_HALF: f[i] = d[(i / 16) * 16 + 15 - (i % 16)];
                FLIP_WORD: f[i] = d[31 - i];
                default: f[i] = d[i];
            endcase
        end
        return f;
    endfunction

    // ****************************************************************
    // byte engine
    // ****************************************************************
    crcu_byte_step u_step (
        .crc_in(r.crc),
        .byte_in(r.work[31:24]),
        .coeffs(r.coeffs),
        .width_sel(r.generator_width),
        .crc_out(step_crc)
    );

    // ****************************************************************
    // bus phase decode
    // ****************************************************************
    // data port reads wait for the engine so they never see a partial crc;
    // data port writes wait only when the buffer is already taken
    assign blocked = r.a_valid && (r.a_addr == OFF_DATA) &&
        (r.a_write ? (r.eng == CRCU_RUN && r.buf_valid)
                   : (r.eng == CRCU_RUN || r.buf_valid)); // [R2] [R18]
    assign dphase = r.a_valid && !blocked;
    assign wr_fire = dphase && r.a_write;
    assign wr_word = r.a_size == SIZE_WORD;
    assign accept = hsel && htrans[1] && hready;
    assign abort = wr_fire && wr_word &&
        ((r.a_addr == OFF_CTRL && hwdata[CTRL_RST_BIT]) ||
         r.a_addr == OFF_SEED);
    assign hreadyout = !blocked;
    assign hresp = 1'b0; // every access answers okay
    assign hrdata = r.rdata;

    // ****************************************************************
    // input preparation
    // ****************************************************************
    // reversal never reaches past the written width
    always_comb begin
        eff_flip = r.input_bit_flip;
        if (r.a_size == SIZE_BYTE && r.input_bit_flip != FLIP_NONE) begin
            eff_flip = FLIP_BYTE;
        end else if (r.a_size == SIZE_HALF &&
                     r.input_bit_flip == FLIP_WORD) begin
            eff_flip = FLIP_HALF;
        end
        din_flip = flip_lanes(hwdata, eff_flip); // [R7]
        // right-aligned unit moved to the top, first byte at [31:24]
        if (r.a_size == SIZE_BYTE) begin
            din_aligned = {din_flip[7:0], 24'h000000}; // [R3] [R19]
            din_cnt = CYC_BYTE;
        end else if (r.a_size == SIZE_HALF) begin
            din_aligned = {din_flip[15:0], 16'h0000}; // [R3] [R19]
            din_cnt = CYC_HALF;
        end else begin
            din_aligned = din_flip;
            din_cnt = CYC_WORD; // [R16]
        end
    end

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        nxt = r;
        nxt.soft_rst = 1'b0; // high for one cycle only [R10]
        // engine: one byte per clock, buffer chained without a gap
        if (r.eng == CRCU_RUN) begin
            nxt.crc = step_crc; // [R1] [R16]
            nxt.work = {r.work[23:0], 8'h00};
            nxt.cnt = r.cnt - 3'h1;
            if (r.cnt == 3'h1) begin
                if (r.buf_valid) begin
                    nxt.work = r.buf_data;
                    nxt.cnt = r.buf_cnt;
                    nxt.buf_valid = 1'b0;
                end else begin
                    nxt.eng = CRCU_IDLE;
                end
            end
        end
        // register writes in the data phase
        if (wr_fire) begin
            if (r.a_addr == OFF_DATA) begin
                if (nxt.eng == CRCU_IDLE) begin
                    nxt.eng = CRCU_RUN; // [R1]
                    nxt.work = din_aligned;
                    nxt.cnt = din_cnt;
                end else begin
                    nxt.buf_valid = 1'b1; // no wait state [R18]
                    nxt.buf_data = din_aligned;
                    nxt.buf_cnt = din_cnt;
                end
            end else if (!wr_word) begin
                nxt.soft_rst = 1'b0; // narrow access elsewhere ignored [R19]
            end else if (r.a_addr == OFF_SCRATCH) begin
                nxt.scratch = hwdata[7:0]; // [R4]
            end else if (r.a_addr == OFF_CTRL) begin
                // reserved bits are dropped [R15]
                nxt.output_bit_flip = hwdata[CTRL_OUT_BIT]; // [R6]
                nxt.input_bit_flip = hwdata[CTRL_IN_LO +: 2]; // [R7]
                nxt.generator_width = hwdata[CTRL_WIDTH_LO +: 2]; // [R8]
                if (hwdata[CTRL_RST_BIT]) begin
                    nxt.soft_rst = 1'b1; // [R10]
                    nxt.crc = r.seed; // scratch untouched [R9] [R5]
                    nxt.eng = CRCU_IDLE;
                    nxt.buf_valid = 1'b0;
                end
            end else if (r.a_addr == OFF_SEED) begin
                nxt.seed = hwdata; // [R11]
                nxt.crc = hwdata; // [R17]
                nxt.eng = CRCU_IDLE;
                nxt.buf_valid = 1'b0;
            end else if (r.a_addr == OFF_COEFFS) begin
                nxt.coeffs = hwdata; // [R12]
            end
        end
        // address phase capture
        if (dphase) begin
            nxt.a_valid = 1'b0;
        end
        if (accept) begin
            nxt.a_valid = 1'b1;
            nxt.a_write = hwrite;
            nxt.a_addr = haddr[ADDR_W-1:0];
            nxt.a_size = hsize;
        end
        // read data is refreshed while a read waits for the engine
        rd_addr = accept ? haddr[ADDR_W-1:0] : r.a_addr;
        if ((accept && !hwrite) ||
            (r.a_valid && !r.a_write && blocked)) begin
            if (rd_addr == OFF_DATA) begin
                nxt.rdata = nxt.output_bit_flip ?
                    flip_lanes(nxt.crc, FLIP_WORD) : nxt.crc; // [R2] [R6]
            end else if (rd_addr == OFF_SCRATCH) begin
                nxt.rdata = {24'h000000, nxt.scratch}; // [R4]
            end else if (rd_addr == OFF_CTRL) begin
                nxt.rdata = {24'h000000, nxt.output_bit_flip,
                    nxt.input_bit_flip, nxt.generator_width, 2'h0,
                    nxt.soft_rst};
            end else if (rd_addr == OFF_SEED) begin
                nxt.rdata = nxt.seed;
            end else if (rd_addr == OFF_COEFFS) begin
                nxt.rdata = nxt.coeffs;
            end else begin
                nxt.rdata = 32'h00000000; // unmapped reads zero
            end
        end
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            r <= '0;
            r.crc <= DATA_RST; // [R14]
            r.scratch <= SCRATCH_RST; // [R14]
            r.seed <= SEED_RST; // [R11]
            r.coeffs <= COEFFS_RST; // [R12]
        end else begin
            r <= nxt;
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_word_start;
        wr_fire && r.a_addr == OFF_DATA && wr_word && r.eng == CRCU_IDLE;
    endsequence
    sequence s_four_bytes;
        r.cnt == 3'h4 ##1 r.cnt == 3'h3 ##1 r.cnt == 3'h2
            ##1 r.cnt == 3'h1 && r.eng == CRCU_RUN;
    endsequence
    sequence s_ctrl_reset;
        wr_fire && wr_word && r.a_addr == OFF_CTRL && hwdata[CTRL_RST_BIT];
    endsequence

    property p_reset_vals;
        $fell(rst) |-> r.crc == DATA_RST && r.scratch == 8'h00 &&
            !r.output_bit_flip && r.input_bit_flip == 2'h0 &&
            r.generator_width == 2'h0 && !r.soft_rst;
    endproperty
    a_reset_vals: assert property (p_reset_vals) // [R14]
        else $error("reset values of data, control or scratch wrong");

    property p_seed_coeffs_rst;
        $fell(rst) |-> r.seed == SEED_RST && r.coeffs == COEFFS_RST;
    endproperty
    a_seed_coeffs_rst: assert property (p_seed_coeffs_rst) // [R11] [R12]
        else $error("seed or coefficient reset value wrong");

    property p_ctrl_reset;
        s_ctrl_reset |=> r.crc == $past(r.seed) && r.eng == CRCU_IDLE &&
            r.soft_rst ##1 !r.soft_rst;
    endproperty
    a_ctrl_reset: assert property (p_ctrl_reset) // [R9] [R10]
        else $error("control reset did not reload seed and clear");

    property p_scratch_keep;
        s_ctrl_reset |=> $stable(r.scratch);
    endproperty
    a_scratch_keep: assert property (p_scratch_keep) // [R5]
        else $error("scratch byte changed on control reset");

    property p_seed_load;
        wr_fire && wr_word && r.a_addr == OFF_SEED |=>
            r.crc == $past(hwdata) && r.seed == $past(hwdata);
    endproperty
    a_seed_load: assert property (p_seed_load) // [R17]
        else $error("seed write did not load the data port");

    property p_word_cycles;
        @(posedge clk_sys) disable iff (rst || abort)
        s_word_start |=> s_four_bytes;
    endproperty
    a_word_cycles: assert property (p_word_cycles) // [R16]
        else $error("word computation not four clocks");

    property p_no_wait;
        r.a_valid && r.a_write && r.a_addr == OFF_DATA &&
            r.eng == CRCU_RUN && !r.buf_valid |-> hreadyout;
    endproperty
    a_no_wait: assert property (p_no_wait) // [R18]
        else $error("second data write stalled");

    property p_read_result;
        dphase && !r.a_write && r.a_addr == OFF_DATA |->
            r.eng == CRCU_IDLE && !r.buf_valid &&
            hrdata == (r.output_bit_flip ?
                flip_lanes(r.crc, FLIP_WORD) : r.crc);
    endproperty
    a_read_result: assert property (p_read_result) // [R2] [R6]
        else $error("data port read not the completed result");

    property p_narrow_low;
        r.eng == CRCU_RUN && r.generator_width == WIDTH_16 &&
            nxt.generator_width == WIDTH_16 && !abort
            |=> r.crc[31:16] == 16'h0000;
    endproperty
    a_narrow_low: assert property (p_narrow_low) // [R3]
        else $error("16-bit crc leaked into upper bits");
endmodule

//--- test/crcu_bus_model.sv
// Purpose: processor-side bus master model for the crc unit bench
// Assumes: single slave, hready fed back from hreadyout
// Notes: released address and data show the inverse of the last value
`timescale 1ns/1ps
module crcu_bus_model (
    input wire logic clk_sys,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata
);
    import crcu_pkg::*;
    int waits;

    // ****************************************************************
    // bus phases
    // ****************************************************************
    // idle bus at time zero
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = SIZE_WORD;
        hwdata = 32'h0;
    end

    // hold everything until ready is seen, then step past the edge
    task automatic wait_ready(output logic [31:0] rd);
        int n;
        n = 0;
        @(negedge clk_sys);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 40) tb_top.on_hang();
            @(negedge clk_sys);
        end
        waits = n;
        rd = hrdata;
        @(posedge clk_sys);
        #1;
    endtask

    task automatic addr_phase(input logic wr, input logic [4:0] a,
                              input logic [2:0] sz);
        hsel = 1'b1;
        haddr = {27'h0, a};
        htrans = 2'h2;
        hwrite = wr;
        hsize = sz;
    endtask

    // no latched select after release, so the address is scrambled
    task automatic idle();
        hsel = 1'b0;
        htrans = 2'h0;
        haddr = ~haddr;
    endtask

    task automatic xfer(input logic wr, input logic [4:0] a,
                        input logic [2:0] sz, input logic [31:0] wd,
                        output logic [31:0] rd);
        addr_phase(wr, a, sz);
        wait_ready(rd);
        idle();
        hwdata = wd;
        wait_ready(rd);
        hwdata = ~wd;
    endtask

    // second address phase overlaps the first data phase
    task automatic write_pair(input logic [4:0] a, input logic [31:0] d0,
                              input logic [31:0] d1, output int w1);
        logic [31:0] rd;
        addr_phase(1'b1, a, SIZE_WORD);
        wait_ready(rd);
        hwdata = d0;
        wait_ready(rd);
        idle();
        hwdata = d1;
        wait_ready(rd);
        w1 = waits;
        hwdata = ~d1;
    endtask
endmodule

//--- test/tb_top.sv
// Purpose: self-checking bench of the crc calculation unit
// Assumes: bus model drives one transfer at a time unless paired
// Notes: expected crc values come from a bitwise reference model
`timescale 1ns/1ps
module tb_top;
    import crcu_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    int n_fail = 0;
    int checks_done = 0;
    int w;

    crcu_top dut (.clk_sys(clk_sys), .rst(rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata));
    crcu_bus_model bus (.clk_sys(clk_sys), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hreadyout(hreadyout), .hrdata(hrdata));

    // 25 MHz system clock
    always #20 clk_sys = ~clk_sys;

    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        bus.xfer(1'b1, a, SIZE_WORD, d, rd);
    endtask

    task automatic rdc(input logic [4:0] a, input logic [31:0] e,
                       input string what);
        bus.xfer(1'b0, a, SIZE_WORD, 32'h0, rd);
        chk(what, e, rd);
    endtask

    // one shift per data bit, msb first, state masked to the width
    function automatic logic [31:0] crc_ref(input logic [31:0] crc,
        input logic [31:0] d, input int nb, input logic [31:0] coeff_bits,
        input int wd);
        logic [31:0] m;
        logic fb;
        m = (wd == 32) ? 32'hFFFFFFFF : ((32'h1 << wd) - 32'h1);
        for (int i = nb - 1; i >= 0; i--) begin
            fb = crc[wd-1] ^ d[i];
            crc = (crc << 1) & m;
            if (fb) crc = crc ^ (coeff_bits & m);
        end
        return crc & m;
    endfunction

    // reverse bits inside each group of unit bits; unit 1 is identity
    function automatic logic [31:0] flip(input logic [31:0] d, input int u);
        logic [31:0] r;
        for (int i = 0; i < 32; i++) r[i] = d[(i / u) * u + u - 1 - i % u];
        return r;
    endfunction

    task automatic on_hang();
        n_fail++;
        $display("mismatch bus ready expected 1 seen stuck low");
        report_and_stop();
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_reset();
        chk("hresp", 32'h0, {31'h0, hresp});
        rdc(OFF_DATA, 32'hFFFFFFFF, "data reset");
        rdc(OFF_SCRATCH, 32'h0, "scratch reset");
        rdc(OFF_CTRL, 32'h0, "ctrl reset");
        rdc(OFF_SEED, 32'hFFFFFFFF, "seed reset");
        rdc(OFF_COEFFS, 32'h04C11DB7, "coeffs reset");
        rdc(5'h0C, 32'h0, "unmapped");
    endtask

    task automatic t_scratch();
        wr(OFF_SCRATCH, 32'h000000A5);
        rdc(OFF_SCRATCH, 32'h000000A5, "scratch");
        rdc(OFF_DATA, 32'hFFFFFFFF, "data after scratch");
        wr(OFF_CTRL, 32'h00000001);
        rdc(OFF_SCRATCH, 32'h000000A5, "scratch kept");
        rdc(OFF_CTRL, 32'h0, "ctrl self clear");
        wr(OFF_CTRL, 32'h000000F8);
        rdc(OFF_CTRL, 32'h000000F8, "ctrl fields");
        wr(OFF_CTRL, 32'h0);
    endtask

    task automatic t_seed_out();
        wr(OFF_SEED, 32'h11223344);
        rdc(OFF_DATA, 32'h11223344, "seed load");
        rdc(OFF_SEED, 32'h11223344, "seed");
        wr(OFF_CTRL, 32'h00000080);
        rdc(OFF_DATA, 32'h22CC4488, "out flip");
        wr(OFF_CTRL, 32'h0);
        bus.xfer(1'b1, OFF_SEED, SIZE_BYTE, 32'h000000AA, rd);
        rdc(OFF_SEED, 32'h11223344, "seed byte write");
    endtask

    task automatic t_word();
        wr(OFF_SEED, 32'hFFFFFFFF);
        wr(OFF_DATA, 32'h12345678);
        rdc(OFF_DATA, 32'hDF8A8A2B, "crc32 word");
        wr(OFF_CTRL, 32'h0);
        rdc(OFF_DATA, 32'hDF8A8A2B, "ctrl zero");
        wr(OFF_DATA, 32'h12345678);
        wr(OFF_CTRL, 32'h00000001);
        rdc(OFF_DATA, 32'hFFFFFFFF, "ctrl reload");
    endtask

    // second write must go through with no wait state
    task automatic t_b2b();
        bus.write_pair(OFF_DATA, 32'h12345678, 32'hCAFE0001, w);
        chk("second write waits", 32'h0, 32'(w));
        rdc(OFF_DATA, crc_ref(32'hDF8A8A2B, 32'hCAFE0001, 32,
            32'h04C11DB7, 32), "back to back");
    endtask

    // every width, input flip mode and write size
    task automatic t_modes();
        logic [31:0] pols [4];
        logic [31:0] d;
        logic [31:0] e;
        int wd, nb, u;
        pols = '{32'h04C11DB7, 32'h00001021, 32'h00000007, 32'h00000009};
        for (int p = 0; p < 4; p++) begin
            for (int f = 0; f < 4; f++) begin
                for (int s = 0; s < 3; s++) begin
                    wd = (p == 3) ? 7 : (32 >> p);
                    nb = 8 << s;
                    u = (f == 0) ? 1 :
                        ((8 << (f - 1)) < nb ? 8 << (f - 1) : nb);
                    d = 32'h1A2B3C4D >> (32 - nb);
                    wr(OFF_COEFFS, pols[p]);
                    wr(OFF_CTRL, {24'h0, 1'b0, 2'(f), 2'(p), 3'h1});
                    bus.xfer(1'b1, OFF_DATA, 3'(s), d, rd);
                    e = crc_ref(32'hFFFFFFFF, flip(d, u), nb, pols[p], wd);
                    rdc(OFF_DATA, e, "crc mode");
                end
            end
        end
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        repeat (4) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        t_reset();
        t_scratch();
        t_seed_out();
        t_word();
        t_b2b();
        t_modes();
        report_and_stop();
    end
endmodule
